// file: logic/stp_packetizer.sv
/*
  Serial-side mode logic: transparent byte grouping into radio packets,
  or delimited, escaped frames in frame mode (always on SPI).
  Assumes serial bytes arrive already deserialised, one per strobe,
  synchronous to ref_clk; radio side accepts bytes by valid/ready.
*/
`timescale 1ns/1ps
module stp_packetizer (
  input  wire logic                   ref_clk,          // module clock 40 MHz
  input  wire logic                   rstn,             // async reset, active low
  input  wire logic                   clkEn,            // freezes state while low
  input  wire logic                   serial_mode_select, // 1 = framed
  input  wire logic                   spiActive,        // SPI is the serial port
  input  wire logic [7:0]             packetization_timeout, // idle chars
  input  wire logic [15:0]            bitCycles,        // clocks per baud bit
  input  wire logic                   commandMode,      // command mode active
  input  wire logic                   cmdSeqDetect,     // guard+chars+guard seen
  input  wire logic                   serLineEdge,      // input line toggled
  input  wire logic [7:0]             serRxData,        // received serial byte
  input  wire logic                   serRxValid,       // byte strobe
  output logic [7:0]                  radioTxData,      // byte to radio
  output logic                        radioTxValid,     // radio byte valid
  output logic                        radioTxLast,      // closes a packet
  input  wire logic                   radioTxReady,     // radio takes byte
  input  wire stp_pkg::stp_radio_rx_t radioRx,          // radio payload byte
  input  wire logic                   radioRxValid,     // radio byte valid
  output logic                        radioRxReady,     // serial side takes it
  input  wire stp_pkg::stp_tx_status_t txStatus,        // transmit outcome
  input  wire logic                   txStatusValid,    // outcome strobe
  output logic [7:0]                  serTxData,        // byte to serial out
  output logic                        serTxValid,       // serial byte valid
  input  wire logic                   serTxReady,       // serializer takes it
  output logic                        framedActive,     // framed mode in force
  output logic                        rxDropped         // byte lost on full buffer
);
  typedef enum logic [2:0] {
    OS_IDLE   = 3'b000,
    OS_DELIM  = 3'b001,
    OS_TYPE   = 3'b010,
    OS_ADDR   = 3'b011,
    OS_BODY   = 3'b100,
    OS_STAT   = 3'b101,
    OS_PASS   = 3'b110
  } stp_out_t;

  function automatic logic needsEscape(input logic [7:0] b);
    needsEscape = (b == stp_pkg::FRAME_DELIM) || (b == stp_pkg::FRAME_ESC) ||
                  (b == stp_pkg::XON_CHAR) || (b == stp_pkg::XOFF_CHAR);
  endfunction

  logic        framed;
  logic        fifoInReady;
  logic        fifoOutValid;
  logic [8:0]  fifoOut;
  logic        fifoPop;
  logic        accept;
  logic        closeNow;
  logic        idleExpired;
  logic [6:0]  count_reg;
  logic        pending_reg;
  logic        closeCmd_reg;
  stp_pkg::stp_byte_t inWord;

  // ****************************************
  // mode selection
  // ****************************************
  assign framed = serial_mode_select || spiActive;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      framedActive <= stp_pkg::MODE_RESET;
    end else if (clkEn) begin
      framedActive <= framed;
    end
  end

  // ****************************************
  // serial to radio
  // ****************************************
  // in framed mode the host frame parser owns the input; here only
  // transparent bytes are grouped, and command-mode bytes stay local
  assign accept = serRxValid && !framedActive && !commandMode;

  stp_char_timer u_timer (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .clkEn     (clkEn),
    .bitCycles (bitCycles),
    .charCount (packetization_timeout),
    .activity  (serLineEdge || serRxValid),
    .arm       (pending_reg && (packetization_timeout != 8'h00)),
    .expired   (idleExpired)
  );

  // close marks the byte being written as the packet's last
  always_comb begin
    closeNow = 1'b0;
    if (packetization_timeout == 8'h00) begin
      closeNow = 1'b1;
    end
    if (count_reg == 7'(stp_pkg::MAX_PAYLOAD - 1)) begin
      closeNow = 1'b1;
    end
  end

  assign inWord.data = serRxData;
  assign inWord.last = closeNow;

  // a timeout or command flush with no byte in hand tags the output side
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_reg    <= '0;
      pending_reg  <= 1'b0;
      closeCmd_reg <= 1'b0;
      rxDropped    <= 1'b0;
    end else if (clkEn) begin
      rxDropped <= accept && !fifoInReady;
      // clear first so that a new flush in the same cycle wins
      if (closeCmd_reg && radioTxValid && radioTxReady && !fifoOutValid) begin
        closeCmd_reg <= 1'b0;
      end
      if (accept && fifoInReady) begin
        count_reg   <= closeNow ? '0 : count_reg + 7'd1;
        pending_reg <= !closeNow;
      end else if ((idleExpired || cmdSeqDetect) && pending_reg) begin
        count_reg    <= '0;
        pending_reg  <= 1'b0;
        // nothing left to mark when the last byte already left: close lost
        closeCmd_reg <= fifoOutValid || (radioTxValid && !radioTxReady);
      end
    end
  end

  stp_fifo #(
    .WIDTH (stp_pkg::FIFO_WIDTH + 1),
    .DEPTH (stp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .clkEn    (clkEn),
    .inData   (inWord),
    .inValid  (accept),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (fifoOutValid),
    .outReady (fifoPop)
  );

  // output stage register; a deferred close marks the final byte only while it waits with radioTxReady low
  assign fifoPop = fifoOutValid && (!radioTxValid || radioTxReady) && clkEn;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      radioTxData  <= '0;
      radioTxValid <= 1'b0;
      radioTxLast  <= 1'b0;
    end else if (clkEn) begin
      if (fifoPop) begin
        radioTxData  <= fifoOut[8:1];
        radioTxValid <= 1'b1;
        radioTxLast  <= fifoOut[0];
      end else if (radioTxReady) begin
        radioTxValid <= 1'b0;
      end else if (radioTxValid && closeCmd_reg && !fifoOutValid) begin
        radioTxLast <= 1'b1;
      end
    end
  end

  // ****************************************
  // radio to serial
  // ****************************************
  stp_out_t    os_reg;
  logic [1:0]  idx_reg;
  logic        escPend_reg;
  logic [7:0]  escByte_reg;
  logic [7:0]  statId_reg;
  logic [7:0]  statCode_reg;
  logic        statPend_reg;
  logic [7:0]  curByte;
  logic        canSend;

  assign canSend = !serTxValid || serTxReady;

  always_comb begin
    curByte = radioRx.data;
    case (os_reg)
      OS_DELIM: curByte = stp_pkg::FRAME_DELIM;
      OS_TYPE:  curByte = statPend_reg ? stp_pkg::TYPE_TX_STATUS : stp_pkg::TYPE_RX_DATA;
      OS_ADDR:  curByte = radioRx.srcAddr[8*(3-idx_reg) +: 8];
      OS_STAT:  curByte = idx_reg[0] ? statCode_reg : statId_reg;
      default:  curByte = radioRx.data;
    endcase
  end

  assign radioRxReady = clkEn && canSend && !escPend_reg &&
                        ((os_reg == OS_PASS) || (os_reg == OS_BODY));

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      statPend_reg <= 1'b0;
      statId_reg   <= '0;
      statCode_reg <= '0;
    end else if (clkEn) begin
      if (txStatusValid && framedActive) begin
        statPend_reg <= 1'b1;
        statId_reg   <= txStatus.frameId;
        statCode_reg <= txStatus.status;
      end else if (os_reg == OS_STAT && idx_reg[0] && canSend) begin
        statPend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      os_reg      <= OS_IDLE;
      idx_reg     <= '0;
      escPend_reg <= 1'b0;
      escByte_reg <= '0;
      serTxData   <= '0;
      serTxValid  <= 1'b0;
    end else if (clkEn && canSend) begin
      serTxValid <= 1'b0;
      if (escPend_reg) begin
        serTxData   <= escByte_reg ^ stp_pkg::ESC_XOR;
        serTxValid  <= 1'b1;
        escPend_reg <= 1'b0;
      end else begin
        case (os_reg)
          OS_IDLE: begin
            if (!framedActive && radioRxValid) begin
              os_reg <= OS_PASS;
            end else if (framedActive && (statPend_reg || radioRxValid)) begin
              os_reg <= OS_DELIM;
            end
          end
          OS_PASS: begin
            if (radioRxValid) begin
              serTxData  <= radioRx.data;
              serTxValid <= 1'b1;
            end else begin
              os_reg <= OS_IDLE;
            end
          end
          OS_DELIM: begin
            serTxData  <= curByte;
            serTxValid <= 1'b1;
            os_reg     <= OS_TYPE;
          end
          OS_TYPE, OS_ADDR, OS_STAT, OS_BODY: begin
            if (os_reg != OS_BODY || radioRxValid) begin
              if (needsEscape(curByte)) begin
                serTxData   <= stp_pkg::FRAME_ESC;
                escByte_reg <= curByte;
                escPend_reg <= 1'b1;
              end else begin
                serTxData <= curByte;
              end
              serTxValid <= 1'b1;
              idx_reg    <= idx_reg + 2'd1;
              if (os_reg == OS_TYPE) begin
                idx_reg <= '0;
                os_reg  <= statPend_reg ? OS_STAT : OS_ADDR;
              end else if (os_reg == OS_ADDR && idx_reg == 2'd3) begin
                os_reg <= OS_BODY;
              end else if (os_reg == OS_STAT && idx_reg[0]) begin
                os_reg <= OS_IDLE;
              end else if (os_reg == OS_BODY && radioRx.last) begin
                os_reg <= OS_IDLE;
              end
            end
          end
          default: os_reg <= OS_IDLE;
        endcase
      end
    end
  end
endmodule // stp_packetizer

// file: logic/stp_pkg.sv
/*
  Shared constants and carrier types of the serial-to-radio packetizer.
  Assumes one 40 MHz module clock; all users name items as stp_pkg::name.
*/
package stp_pkg;
  // ****************************************
  // timing and sizes
  // ****************************************
  localparam int CLK_HZ          = 40_000_000;
  localparam int MIN_IDLE_US     = 100;
  localparam int MIN_IDLE_CYC    = (MIN_IDLE_US * (CLK_HZ / 1_000_000));
  localparam int CHAR_BITS       = 10;
  localparam int MAX_PAYLOAD     = 100;
  localparam int FIFO_DEPTH      = 4;
  localparam int FIFO_WIDTH      = 8;
  localparam int FRAME_MAX       = 128;

  // ****************************************
  // reset values and encodings
  // ****************************************
  localparam logic       MODE_TRANSPARENT = 1'b0;
  localparam logic       MODE_FRAMED      = 1'b1;
  localparam logic       MODE_RESET       = MODE_TRANSPARENT;
  localparam logic [7:0] FRAME_DELIM      = 8'h7E;
  localparam logic [7:0] FRAME_ESC        = 8'h7D;
  localparam logic [7:0] ESC_XOR          = 8'h20;
  localparam logic [7:0] XON_CHAR         = 8'h11;
  localparam logic [7:0] XOFF_CHAR        = 8'h13;
  localparam logic [7:0] TYPE_TX_STATUS   = 8'h89;
  localparam logic [7:0] TYPE_RX_DATA     = 8'hB0;
  localparam logic [7:0] CMD_CHAR_RESET   = 8'h2B;

  typedef enum logic [1:0] {
    CLOSE_NONE  = 2'b00,
    CLOSE_IDLE  = 2'b01,
    CLOSE_CMD   = 2'b10,
    CLOSE_FULL  = 2'b11
  } stp_close_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } stp_byte_t;

  typedef struct packed {
    logic [31:0] srcAddr;
    logic [7:0]  data;
    logic        first;
    logic        last;
  } stp_radio_rx_t;

  typedef struct packed {
    logic [7:0] frameId;
    logic [7:0] status;
  } stp_tx_status_t;
endpackage

// file: logic/stp_fifo.sv
/*
  Small valid/ready FIFO with parameterised width and depth.
  Assumes a single clock; clkEn low freezes all state.
*/
`timescale 1ns/1ps
module stp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk,  // module clock
  input  wire logic             rstn,     // async reset, active low
  input  wire logic             clkEn,    // state freezes while low
  input  wire logic [WIDTH-1:0] inData,   // write data
  input  wire logic             inValid,  // write request
  output logic                  inReady,  // room for a word
  output logic [WIDTH-1:0]      outData,  // read data, combinational read of the head entry
  output logic                  outValid, // read data valid
  input  wire logic             outReady  // reader takes word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign pop     = outValid && outReady;
  assign push    = inValid && inReady;
  assign inReady = (count_reg != (AW+1)'(DEPTH));

  // ****************************************
  // storage
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (clkEn && push) begin
      mem_reg[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else if (clkEn) begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  assign outValid = (count_reg != '0);
  assign outData  = mem_reg[rdPtr_reg];
endmodule // stp_fifo

// file: logic/stp_char_timer.sv
/*
  Idle timer: counts ref_clk cycles with no serial transition and flags
  expiry after a configured number of character times, never below the
  minimum idle time. Assumes bitCycles is the clock count of one bit.
*/
`timescale 1ns/1ps
module stp_char_timer (
  input  wire logic        ref_clk,   // module clock
  input  wire logic        rstn,      // async reset, active low
  input  wire logic        clkEn,     // state freezes while low
  input  wire logic [15:0] bitCycles, // clocks per serial bit
  input  wire logic [7:0]  charCount, // idle length in characters
  input  wire logic        activity,  // serial line transition seen
  input  wire logic        arm,       // data is pending
  output logic             expired    // one-cycle pulse on timeout
);
  logic [31:0] limit;
  logic [31:0] idle_reg;
  logic        fired_reg;

  // character time = start + data + stop bits of one character
  always_comb begin
    limit = 32'(bitCycles) * 32'(stp_pkg::CHAR_BITS) * 32'(charCount);
    if (limit < 32'(stp_pkg::MIN_IDLE_CYC)) begin
      limit = 32'(stp_pkg::MIN_IDLE_CYC);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      idle_reg  <= '0;
      fired_reg <= 1'b0;
      expired   <= 1'b0;
    end else if (clkEn) begin
      expired <= 1'b0;
      if (activity || !arm) begin
        idle_reg  <= '0;
        fired_reg <= 1'b0;
      end else if (!fired_reg) begin
        if (idle_reg + 32'd1 >= limit) begin
          fired_reg <= 1'b1;
          expired   <= 1'b1;
        end
        idle_reg <= idle_reg + 32'd1;
      end
    end
  end
endmodule // stp_char_timer

// file: verif/stp_packetizer_sva.sv
/*
  Port checker for the serial-to-radio packetizer.
  Assumes it is bound to stp_packetizer; one clock, async low reset.
*/
`timescale 1ns/1ps
module stp_packetizer_sva (
  input wire logic       ref_clk,               // module clock
  input wire logic       rstn,                  // async reset, active low
  input wire logic       clkEn,                 // run enable
  input wire logic       serial_mode_select,    // 1 = framed
  input wire logic       spiActive,             // SPI port in use
  input wire logic [7:0] packetization_timeout, // idle chars
  input wire logic       serRxValid,            // serial byte strobe
  input wire logic [7:0] radioTxData,           // byte to radio
  input wire logic       radioTxValid,          // radio byte valid
  input wire logic       radioTxLast,           // packet end
  input wire logic       radioTxReady,          // radio takes byte
  input wire logic [7:0] serTxData,             // byte to serial
  input wire logic       serTxValid,            // serial byte valid
  input wire logic       serTxReady,            // serializer takes byte
  input wire logic       framedActive,          // framed mode in force
  input wire logic       rxDropped              // byte lost
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ****************************************
  // assertions
  // ****************************************
  a_reset_quiet: assert property ($rose(rstn) |-> !framedActive && !radioTxValid)
    else $error("outputs busy right after reset");
  a_mode_default: assert property ($past(rstn) && $past(clkEn) && !$past(serial_mode_select)
    && !$past(spiActive) |-> !framedActive)
    else $error("framed without request");
  a_mode_select: assert property ($past(rstn) && $past(clkEn) && $past(serial_mode_select)
    |-> framedActive)
    else $error("mode select ignored");
  a_spi_framed: assert property ($past(rstn) && $past(clkEn) && $past(spiActive)
    |-> framedActive)
    else $error("SPI without framed mode");
  a_drop_cause: assert property (rxDropped |-> $past(serRxValid))
    else $error("drop without incoming byte");
  a_drop_full: assert property (rxDropped |-> $past(radioTxValid) && !$past(radioTxReady))
    else $error("drop while output drains");
  a_radio_hold: assert property (radioTxValid && !radioTxReady
    |=> radioTxValid && $stable(radioTxData))
    else $error("radio byte changed before taken");
  a_serial_hold: assert property (serTxValid && !serTxReady
    |=> serTxValid && $stable(serTxData))
    else $error("serial byte changed before taken");
  a_zero_last: assert property (packetization_timeout == 8'h00 && radioTxValid
    |-> radioTxLast)
    else $error("byte not closed with zero timeout");
  c_drop: cover property (rxDropped);
  c_close: cover property (radioTxValid && radioTxLast && radioTxReady);
  c_framed: cover property (framedActive && serTxValid && serTxReady);
endmodule // stp_packetizer_sva

bind stp_packetizer stp_packetizer_sva u_sva (.ref_clk, .rstn, .clkEn, .serial_mode_select,
  .spiActive, .packetization_timeout, .serRxValid, .radioTxData, .radioTxValid, .radioTxLast,
  .radioTxReady, .serTxData, .serTxValid, .serTxReady, .framedActive, .rxDropped);

// file: verif/stp_host_model.sv
/*
  Host model: sends deserialised bytes and sinks serial output bytes.
  Assumes inputs change at falling edges; output bytes land in got.
*/
`timescale 1ns/1ps
module stp_host_model (
  input  wire logic       ref_clk,     // module clock
  input  wire logic [7:0] serTxData,   // byte from device
  input  wire logic       serTxValid,  // device byte valid
  input  wire logic       slow,        // stall the sink
  output logic [7:0]      serRxData,   // byte to device
  output logic            serRxValid,  // byte strobe
  output logic            serLineEdge, // line toggled
  output logic            serTxReady   // sink takes byte
);
  logic [7:0] got[$];
  logic [1:0] stallCnt = 2'b00;
  initial begin
    serRxData = 8'h00;
    serRxValid = 1'b0;
    serLineEdge = 1'b0;
    serTxReady = 1'b0;
  end
  task automatic send_byte(input logic [7:0] b);
    @(negedge ref_clk);
    serRxData = b;
    serRxValid = 1'b1;
    serLineEdge = 1'b1;
    @(negedge ref_clk);
    serRxData = ~b; // released data never repeats the old value
    serRxValid = 1'b0;
    serLineEdge = 1'b0;
  endtask
  always @(negedge ref_clk) begin
    stallCnt <= stallCnt + 2'd1;
    serTxReady <= !slow || stallCnt == 2'd3;
  end
  always @(posedge ref_clk) begin
    if (serTxValid === 1'b1 && serTxReady) begin
      got.push_back(serTxData);
    end
  end
endmodule // stp_host_model

// file: verif/serial_to_radio_packetizer_test.sv
/*
  Self-checking bench for stp_packetizer with a host model on the serial side.
  Assumes the design's 40 MHz clock and 4000-cycle idle minimum.
*/
`timescale 1ns/1ps
module serial_to_radio_packetizer_test;
  logic ref_clk, rstn, mode, spi, cmdMode, cmdSeq, txReady, rxValid, stsValid, slow, dropSeen, en;
  logic [7:0] tmo, radioTxData, serTxData, serRxData;
  logic [15:0] bitc;
  logic radioTxValid, radioTxLast, radioRxReady, serTxValid, serTxReady, serRxValid, lineEdge;
  logic framedActive, rxDropped;
  stp_pkg::stp_radio_rx_t radioRx;
  stp_pkg::stp_tx_status_t sts;
  int err_total, compares;
  stp_packetizer u_dut (.ref_clk, .rstn, .clkEn(en), .serial_mode_select(mode),
    .spiActive(spi), .packetization_timeout(tmo), .bitCycles(bitc), .commandMode(cmdMode),
    .cmdSeqDetect(cmdSeq), .serLineEdge(lineEdge), .serRxData, .serRxValid, .radioTxData,
    .radioTxValid, .radioTxLast, .radioTxReady(txReady), .radioRx, .radioRxValid(rxValid),
    .radioRxReady, .txStatus(sts), .txStatusValid(stsValid), .serTxData, .serTxValid,
    .serTxReady, .framedActive, .rxDropped);
  stp_host_model u_host (.ref_clk, .serTxData, .serTxValid, .slow, .serRxData, .serRxValid,
    .serLineEdge(lineEdge), .serTxReady);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (!rstn) dropSeen <= 1'b0;
    else if (rxDropped === 1'b1) dropSeen <= 1'b1;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic m, input logic s, input logic [7:0] t);
    @(negedge ref_clk);
    rstn = 1'b0;
    {mode, spi, tmo, bitc, cmdMode, slow} = {m, s, t, 16'h000A, 2'h0};
    u_host.got.delete();
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    // let one edge load the registered mode before anything is judged
    @(negedge ref_clk);
  endtask
  task automatic get_tx(input logic [7:0] d, input logic l, input int lim);
    int n;
    n = 0;
    while ({radioTxValid, radioTxLast} !== {1'b1, l} && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    check({radioTxValid, radioTxLast, radioTxData}, {1'b1, l, d});
    txReady = 1'b1;
    @(negedge ref_clk);
    txReady = 1'b0;
  endtask
  task automatic put_rx(input logic [31:0] a, input logic [7:0] d, input logic f, input logic l);
    int n;
    n = 0;
    @(negedge ref_clk);
    radioRx = '{srcAddr: a, data: d, first: f, last: l};
    rxValid = 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (radioRxReady !== 1'b1 && n < 50);
    @(negedge ref_clk);
    rxValid = 1'b0;
    radioRx = ~radioRx;
  endtask
  task automatic expect_ser(input logic [7:0] e[$]);
    int n;
    n = 0;
    while (u_host.got.size() < e.size() && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    foreach (e[i]) check(u_host.got.size() > i ? u_host.got[i] : 8'hxx, e[i]);
    u_host.got.delete();
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_basic();
    do_reset(1'b0, 1'b0, 8'h00);
    check({framedActive, radioTxValid, serTxValid}, 3'b000);
    u_host.send_byte(8'hA5);
    get_tx(8'hA5, 1'b1, 20);
    u_host.send_byte(8'h5A);
    get_tx(8'h5A, 1'b1, 20);
  endtask
  task automatic t_idle(input logic [7:0] t, input int quiet);
    do_reset(1'b0, 1'b0, t);
    bitc = 16'h0014;
    u_host.send_byte(8'h3C);
    repeat (quiet) @(negedge ref_clk);
    check(radioTxLast, 1'b0);
    get_tx(8'h3C, 1'b1, 500);
  endtask
  task automatic t_cmd();
    do_reset(1'b0, 1'b0, 8'hC8);
    u_host.send_byte(8'h11);
    repeat (10) @(negedge ref_clk);
    check(radioTxLast, 1'b0);
    cmdSeq = 1'b1;
    @(negedge ref_clk);
    cmdSeq = 1'b0;
    get_tx(8'h11, 1'b1, 10);
    cmdMode = 1'b1;
    u_host.send_byte(8'h22);
    repeat (30) @(negedge ref_clk);
    check(radioTxValid, 1'b0);
  endtask
  task automatic t_full();
    do_reset(1'b0, 1'b0, 8'hC8);
    for (int i = 0; i < 100; i++) begin
      u_host.send_byte(i[7:0]);
      get_tx(i[7:0], i == 99, 20);
    end
  endtask
  task automatic t_overflow();
    do_reset(1'b0, 1'b0, 8'hC8);
    for (int i = 0; i < 7; i++) u_host.send_byte(8'hA0 + i[7:0]);
    check(dropSeen, 1'b1);
    for (int i = 0; i < 4; i++) get_tx(8'hA0 + i[7:0], 1'b0, 20);
  endtask
  task automatic t_freeze();
    do_reset(1'b0, 1'b0, 8'h00);
    u_host.send_byte(8'h69);
    repeat (2) @(negedge ref_clk);
    en = 1'b0;
    txReady = 1'b1;
    repeat (3) @(negedge ref_clk);
    check({radioTxValid, radioTxData}, {1'b1, 8'h69});
    txReady = 1'b0;
    en = 1'b1;
    get_tx(8'h69, 1'b1, 20);
  endtask
  task automatic t_framed();
    do_reset(1'b1, 1'b0, 8'h00);
    slow = 1'b1;
    check(framedActive, 1'b1);
    put_rx(32'h1234_7E56, 8'h11, 1'b1, 1'b1);
    expect_ser('{8'h7E, 8'hB0, 8'h12, 8'h34, 8'h7D, 8'h5E, 8'h56, 8'h7D, 8'h31});
    @(negedge ref_clk);
    sts = '{frameId: 8'h05, status: 8'h7D};
    stsValid = 1'b1;
    @(negedge ref_clk);
    stsValid = 1'b0;
    expect_ser('{8'h7E, 8'h89, 8'h05, 8'h7D, 8'h5D});
  endtask
  task automatic t_spi_and_rx();
    do_reset(1'b0, 1'b1, 8'h00);
    check(framedActive, 1'b1);
    u_host.send_byte(8'h33);
    repeat (20) @(negedge ref_clk);
    check(radioTxValid, 1'b0);
    do_reset(1'b0, 1'b0, 8'h00);
    slow = 1'b1;
    put_rx(32'hAAAA_5555, 8'h7E, 1'b1, 1'b0);
    put_rx(32'hAAAA_5555, 8'h7D, 1'b0, 1'b1);
    expect_ser('{8'h7E, 8'h7D});
  endtask
  // ****************************************
  // run control
  // ****************************************
  task automatic wrap_up();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {rstn, mode, spi, cmdMode, cmdSeq, txReady, rxValid, stsValid, slow} = 9'h000;
    en = 1'b1;
    {tmo, bitc, radioRx, sts} = '0;
    err_total = 0;
    compares = 0;
    t_basic();
    t_idle(8'h01, 3900);
    t_idle(8'h19, 4800);
    t_cmd();
    t_full();
    t_overflow();
    t_freeze();
    t_framed();
    t_spi_and_rx();
    wrap_up();
  end
  initial begin
    #1_500_000; // about six times the expected run
    err_total++;
    wrap_up();
  end
endmodule // serial_to_radio_packetizer_test
